//--- ppl3_tx_link.sv
`timescale 1ns/1ps
`include "ppl3_params.svh"

// Behaviour
// R01 - Link-clock reset is active low, asserts any time, releases on link clock.
// R02 - Receive-clock reset is active low, releases aligned to receive clock.
// R03 - Streaming-side reset may assert asynchronously, releases on its own clock.
// R04 - All streaming-side signals are sampled on one rising clock edge.
// R05 - Resetting any one channel means resetting every channel of the core; here link reset alone leaves the streaming side running.
// R06 - Link side drives every link-to-PHY signal and receives PHY-to-link ones.
// R07 - PHY side takes link-to-PHY signals as inputs, drives PHY-to-link outputs.
// R08 - Transmit transfers are synchronous to the link clock, up to 104 MHz.
// R09 - Data bus is big-endian and valid only while write enable is asserted.
// R10 - In 8-bit width only the lowest byte lane of data is used.
// R11 - Start marker rides the first word of every packet, with enable.
// R12 - End marker rides the last word of every packet, with enable.
// R13 - Error flag aborts the packet and appears only with the end marker.
// R14 - Parity covers data bus, valid with enable; PHY checks both senses.
// R15 - PHY reports parity mismatch upward but passes data unchanged.
// R16 - Modulo 00 all bytes, 01 upper three, 10 upper two, 11 top byte.
// R17 - Modulo stays zero except on the last word of a packet.
// R18 - Write enable is active low; while high the other signals are ignored.
// R19 - Parity is XOR of active lanes, odd or even sense selectable.
module ppl3_tx_link
  import ppl3_pkg::*;
#(
  parameter int BUS_BYTES = `PPL3_BUS_BYTES,
  parameter int FIFO_DEPTH = `PPL3_FIFO_DEPTH,
  parameter int CNT_W = `PPL3_CNT_W
) (
  input wire logic clock, // Streaming-side clock
  input wire logic sys_rst, // Streaming-side reset
  input wire logic in_valid, // User word valid
  output logic in_ready, // Buffer has room
  input wire logic [`PPL3_DATA_W-1:0] in_data, // User word, big-endian
  input wire logic in_sop, // First word of a packet
  input wire logic in_eop, // Last word of a packet
  input wire logic in_err, // Abort this packet
  input wire logic [`PPL3_MOD_W-1:0] in_mod, // Unused bytes of last word
  input wire logic parity_odd, // Parity sense, 1 odd
  output logic frame_fault, // Malformed framing seen
  output logic [CNT_W-1:0] pkt_count, // Packets accepted
  input wire logic link_clk, // Transmit link clock
  input wire logic link_rst_n, // Transmit link reset
  input wire logic phy_room, // PHY can take a word
  output logic tx_enb_n, // Transmit write enable
  output logic [`PPL3_DATA_W-1:0] tx_dat, // Transmit data
  output logic tx_sop, // Transmit start marker
  output logic tx_eop, // Transmit end marker
  output logic tx_err, // Transmit abort
  output logic [`PPL3_MOD_W-1:0] tx_mod, // Transmit modulo
  output logic tx_prty // Transmit parity
);
  localparam int WW = $bits(ppl3_word_t);

  ppl3_fifo_if #(.W(WW)) wr_if ();
  ppl3_fifo_if #(.W(WW)) rd_if ();

  // ****************************************
  // Streaming side framing filter
  // ****************************************
  ppl3_ustate_t ust_q;
  logic take;
  logic keep;
  logic sop_clean;
  logic fault_q;
  logic [CNT_W-1:0] cnt_q;
  ppl3_word_t uw;

  // R04 single-edge sampling
  assign take = in_valid & wr_if.ready;

  always_comb begin
    keep = 1'b1;
    sop_clean = in_sop;
    case (ust_q)
      PPL3_U_IDLE: begin
        keep = in_sop;
      end
      PPL3_U_PKT: begin
        // A start inside a packet is stripped so the open packet survives
        sop_clean = 1'b0;
      end
      default: begin
        keep = 1'b0;
      end
    endcase
  end

  always_comb begin
    uw.sop = sop_clean;
    uw.eop = in_eop;
    // R13 abort only with end
    uw.err = in_err & in_eop;
    // R17 modulo zero mid-packet
    uw.modulo = in_eop ? in_mod : `PPL3_MOD_ALL;
    uw.data = in_data;
  end

  assign wr_if.valid = in_valid & keep;
  assign wr_if.data = uw;
  assign in_ready = wr_if.ready;

  // R03 reset leaves on a clock edge
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ust_q <= PPL3_U_IDLE;
    end else if (take && keep) begin
      ust_q <= in_eop ? PPL3_U_IDLE : PPL3_U_PKT;
    end
  end

  // R11 every packet opens with start
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      fault_q <= 1'b0;
    end else begin
      fault_q <= take & (~keep | (in_sop & (ust_q == PPL3_U_PKT)));
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cnt_q <= '0;
    end else if (take && keep && in_eop) begin
      cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  assign frame_fault = fault_q;
  assign pkt_count = cnt_q;

  // ****************************************
  // Buffer between the two clocks
  // ****************************************
  logic lrst_n;

  ppl3_afifo #(.W(WW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .wclk(clock),
    .wsrst(sys_rst),
    .wr(wr_if.snk),
    .rclk(link_clk),
    .rarst_n(lrst_n),
    .rd(rd_if.src)
  );

  // ****************************************
  // Link clock reset
  // ****************************************
  logic arst_src_n;
  logic [1:0] lrst_q;

  // R05 streaming reset also clears the link side
  assign arst_src_n = link_rst_n & ~sys_rst;

  // R01 assert at once, release on link clock
  always_ff @(posedge link_clk or negedge arst_src_n) begin
    if (!arst_src_n) begin
      lrst_q <= 2'h0;
    end else begin
      lrst_q <= {lrst_q[0], 1'b1};
    end
  end

  assign lrst_n = lrst_q[1];

  logic odd_l;

  ppl3_sync #(.W(1)) u_odd_sync (
    .clk(link_clk),
    .arst_n(lrst_n),
    .srst(1'b0),
    .d(parity_odd),
    .q(odd_l)
  );

  // ****************************************
  // Link side sequencer
  // ****************************************
  ppl3_lstate_t lst_q;
  ppl3_word_t hw_q;
  ppl3_word_t rw;
  logic [1:0] idx_q;
  logic [1:0] last_q;
  logic [1:0] last_d;
  logic emit;
  logic e_sop, e_eop, e_err;
  logic [`PPL3_MOD_W-1:0] e_mod;
  logic [`PPL3_DATA_W-1:0] e_dat;
  logic [7:0] e_byte;

  assign rw = rd_if.data;

  // Byte mode sends the active bytes only; modulo counts unused ones
  assign last_d = rw.eop ? ~rw.modulo : 2'h3;

  always_comb begin
    rd_if.ready = 1'b0;
    emit = 1'b0;
    e_sop = 1'b0;
    e_eop = 1'b0;
    e_err = 1'b0;
    e_mod = `PPL3_MOD_ALL;
    e_dat = '0;
    e_byte = 8'h00;
    if (BUS_BYTES == 4) begin
      rd_if.ready = phy_room;
      emit = phy_room & rd_if.valid;
      e_sop = rw.sop;
      e_eop = rw.eop;
      e_err = rw.err;
      // R16 modulo passes through unchanged
      e_mod = rw.modulo;
      e_dat = rw.data;
    end else begin
      case (lst_q)
        PPL3_L_IDLE: begin
          rd_if.ready = phy_room;
          emit = phy_room & rd_if.valid;
          e_sop = rw.sop;
          e_eop = rw.eop & (last_d == 2'h0);
          e_err = rw.err & (last_d == 2'h0);
          e_byte = rw.data[31:24];
        end
        PPL3_L_BYTES: begin
          emit = phy_room;
          e_eop = hw_q.eop & (idx_q == last_q);
          e_err = hw_q.err & (idx_q == last_q);
          // R09 most significant byte goes first
          case (idx_q)
            2'h1: e_byte = hw_q.data[23:16];
            2'h2: e_byte = hw_q.data[15:8];
            default: e_byte = hw_q.data[7:0];
          endcase
        end
        default: begin
          emit = 1'b0;
        end
      endcase
      // R10 only the low lane carries bytes
      e_dat = {{(`PPL3_DATA_W-8){1'b0}}, e_byte};
    end
  end

  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      lst_q <= PPL3_L_IDLE;
      hw_q <= '0;
      idx_q <= 2'h0;
      last_q <= 2'h0;
    end else if (BUS_BYTES != 4) begin
      case (lst_q)
        PPL3_L_IDLE: begin
          if (emit && last_d != 2'h0) begin
            hw_q <= rw;
            idx_q <= 2'h1;
            last_q <= last_d;
            lst_q <= PPL3_L_BYTES;
          end
        end
        PPL3_L_BYTES: begin
          if (emit) begin
            idx_q <= idx_q + 2'h1;
            if (idx_q == last_q) begin
              lst_q <= PPL3_L_IDLE;
            end
          end
        end
        default: begin
          lst_q <= PPL3_L_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Link pins
  // ****************************************
  logic enb_n_q, sop_q, eop_q, err_q, prty_q;
  logic [`PPL3_MOD_W-1:0] mod_q;
  logic [`PPL3_DATA_W-1:0] dat_q;

  // R06 link side drives every link-to-PHY pin
  // R08 all pins change on the link clock
  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      enb_n_q <= 1'b1;
      dat_q <= '0;
      sop_q <= 1'b0;
      eop_q <= 1'b0;
      err_q <= 1'b0;
      mod_q <= `PPL3_MOD_ALL;
      prty_q <= 1'b0;
    end else begin
      // R18 enable low only on a real word
      enb_n_q <= ~emit;
      // R09 idle cycles drive zeros
      dat_q <= emit ? e_dat : '0;
      // R12 end marker on the last word
      sop_q <= emit & e_sop;
      eop_q <= emit & e_eop;
      err_q <= emit & e_err;
      mod_q <= emit ? e_mod : `PPL3_MOD_ALL;
      // R19 parity sense from the odd selector
      // R14 parity only with enable
      prty_q <= emit & ((^e_dat) ^ odd_l);
    end
  end

  assign tx_enb_n = enb_n_q;
  assign tx_dat = dat_q;
  assign tx_sop = sop_q;
  assign tx_eop = eop_q;
  assign tx_err = err_q;
  assign tx_mod = mod_q;
  assign tx_prty = prty_q;
endmodule

//--- ppl3_params.svh
`ifndef PPL3_PARAMS_SVH
`define PPL3_PARAMS_SVH

// ****************************************
// Widths and depths
// ****************************************
`define PPL3_DATA_W 32
`define PPL3_MOD_W 2
`define PPL3_FIFO_DEPTH 32
`define PPL3_BUS_BYTES 4
`define PPL3_CNT_W 16

// ****************************************
// Modulo codes for the last word
// ****************************************
`define PPL3_MOD_ALL 2'h0
`define PPL3_MOD_UP3 2'h1
`define PPL3_MOD_UP2 2'h2
`define PPL3_MOD_UP1 2'h3

// ****************************************
// Clock rates
// ****************************************
`define PPL3_SYS_MHZ 100
`define PPL3_LINK_MAX_MHZ 104

`endif

//--- ppl3_pkg.sv
`include "ppl3_params.svh"

package ppl3_pkg;

  typedef struct packed {
    logic sop;
    logic eop;
    logic err;
    logic [`PPL3_MOD_W-1:0] modulo;
    logic [`PPL3_DATA_W-1:0] data;
  } ppl3_word_t;

  typedef enum logic {
    PPL3_U_IDLE,
    PPL3_U_PKT
  } ppl3_ustate_t;

  typedef enum logic {
    PPL3_L_IDLE,
    PPL3_L_BYTES
  } ppl3_lstate_t;

endpackage

//--- ppl3_fifo_if.sv
`timescale 1ns/1ps

interface ppl3_fifo_if #(
  parameter int W = 8
);
  logic [W-1:0] data;
  logic valid;
  logic ready;

  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface

//--- ppl3_sync.sv
`timescale 1ns/1ps

// Two-stage level synchroniser; use either reset, tie the other inactive
module ppl3_sync #(
  parameter int W = 1
) (
  input wire logic clk, // Destination clock
  input wire logic arst_n, // Asynchronous clear, active low
  input wire logic srst, // Synchronous clear, active high
  input wire logic [W-1:0] d, // Level from another domain
  output logic [W-1:0] q // Synchronised level
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= '0;
      q <= '0;
    end else if (srst) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

//--- ppl3_afifo.sv
`timescale 1ns/1ps

// Dual-clock FIFO with gray-coded pointers; DEPTH must be a power of two
module ppl3_afifo #(
  parameter int W = 8,
  parameter int DEPTH = 32
) (
  input wire logic wclk, // Write clock
  input wire logic wsrst, // Write side reset, synchronous, active high
  ppl3_fifo_if.snk wr, // Write side
  input wire logic rclk, // Read clock
  input wire logic rarst_n, // Read side reset, asynchronous, active low
  ppl3_fifo_if.src rd // Read side
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wbin_q, wgray_q, rbin_q, rgray_q;
  logic [AW:0] wbin_d, wgray_d, rbin_d, rgray_d;
  logic [AW:0] rgray_w, wgray_r;
  logic room_q, empty_q;
  logic winc, rinc;

  // ****************************************
  // Write domain
  // ****************************************
  // Room is kept as a flop so the ready seen upstream is registered
  assign wr.ready = room_q;
  assign winc = wr.valid & room_q;
  assign wbin_d = wbin_q + {{AW{1'b0}}, winc};
  assign wgray_d = (wbin_d >> 1) ^ wbin_d;

  ppl3_sync #(.W(AW + 1)) u_rptr_sync (
    .clk(wclk),
    .arst_n(1'b1),
    .srst(wsrst),
    .d(rgray_q),
    .q(rgray_w)
  );

  always_ff @(posedge wclk) begin
    if (wsrst) begin
      wbin_q <= '0;
      wgray_q <= '0;
      room_q <= 1'b1;
    end else begin
      wbin_q <= wbin_d;
      wgray_q <= wgray_d;
      room_q <= wgray_d != {~rgray_w[AW:AW-1], rgray_w[AW-2:0]};
    end
  end

  always_ff @(posedge wclk) begin
    if (winc) begin
      mem[wbin_q[AW-1:0]] <= wr.data;
    end
  end

  // ****************************************
  // Read domain
  // ****************************************
  assign rd.valid = ~empty_q;
  assign rd.data = mem[rbin_q[AW-1:0]];
  assign rinc = rd.ready & ~empty_q;
  assign rbin_d = rbin_q + {{AW{1'b0}}, rinc};
  assign rgray_d = (rbin_d >> 1) ^ rbin_d;

  ppl3_sync #(.W(AW + 1)) u_wptr_sync (
    .clk(rclk),
    .arst_n(rarst_n),
    .srst(1'b0),
    .d(wgray_q),
    .q(wgray_r)
  );

  always_ff @(posedge rclk or negedge rarst_n) begin
    if (!rarst_n) begin
      rbin_q <= '0;
      rgray_q <= '0;
      empty_q <= 1'b1;
    end else begin
      rbin_q <= rbin_d;
      rgray_q <= rgray_d;
      empty_q <= rgray_d == wgray_r;
    end
  end
endmodule

//--- ppl3_tx_link_properties.sv
`timescale 1ns/1ps
// ***
// Transmit pin and packet count checks
// ***
module ppl3_tx_link_properties #(
  parameter int CNT_W = 16
) (
  input wire logic clock, // Clock
  input wire logic sys_rst, // Reset
  input wire logic in_valid, // Offered
  input wire logic in_ready, // Room
  input wire logic in_eop, // Last
  input wire logic [CNT_W-1:0] pkt_count, // Packets
  input wire logic parity_odd, // Odd
  input wire logic link_clk, // Link clock
  input wire logic link_rst_n, // Link reset
  input wire logic phy_room, // Room
  input wire logic tx_enb_n, // Enable
  input wire logic [31:0] tx_dat, // Data
  input wire logic tx_sop, // Start
  input wire logic tx_eop, // End
  input wire logic tx_err, // Abort
  input wire logic [1:0] tx_mod, // Modulo
  input wire logic tx_prty // Parity
);
  property p_sop;
    @(posedge link_clk) disable iff (!link_rst_n) tx_sop |-> !tx_enb_n;
  endproperty
  a_sop: assert property (p_sop) else $error("sop idle");
  property p_eop;
    @(posedge link_clk) disable iff (!link_rst_n) tx_eop |-> !tx_enb_n;
  endproperty
  a_eop: assert property (p_eop) else $error("eop idle");
  property p_err;
    @(posedge link_clk) disable iff (!link_rst_n) tx_err |-> tx_eop;
  endproperty
  a_err: assert property (p_err) else $error("err alone");
  property p_mod;
    @(posedge link_clk) disable iff (!link_rst_n) tx_mod != 2'h0 |-> tx_eop;
  endproperty
  a_mod: assert property (p_mod) else $error("mod alone");
  property p_idle;
    @(posedge link_clk) disable iff (!link_rst_n)
      tx_enb_n |-> tx_dat == 32'h0 && !tx_prty && tx_mod == 2'h0;
  endproperty
  a_idle: assert property (p_idle) else $error("idle pins");
  property p_prty;
    @(posedge link_clk) disable iff (!link_rst_n)
      !tx_enb_n |-> tx_prty == ((^tx_dat) ^ parity_odd);
  endproperty
  a_prty: assert property (p_prty) else $error("parity");
  property p_room;
    @(posedge link_clk) disable iff (!link_rst_n) !phy_room |=> tx_enb_n;
  endproperty
  a_room: assert property (p_room) else $error("no room");
  property p_cnt;
    @(posedge clock) disable iff (sys_rst) pkt_count != $past(pkt_count)
      |-> $past(in_valid && in_ready && in_eop)
      && pkt_count == $past(pkt_count) + 1'b1;
  endproperty
  a_cnt: assert property (p_cnt) else $error("count");
  c_err: cover property (@(posedge link_clk) tx_err);
  c_mod: cover property (@(posedge link_clk) tx_eop && tx_mod == 2'h3);
  c_full: cover property (@(posedge clock) !sys_rst && !in_ready);
endmodule

bind ppl3_tx_link ppl3_tx_link_properties #(.CNT_W(CNT_W)) u_props (
  .clock(clock), .sys_rst(sys_rst), .in_valid(in_valid),
  .in_ready(in_ready), .in_eop(in_eop), .pkt_count(pkt_count),
  .parity_odd(parity_odd), .link_clk(link_clk), .link_rst_n(link_rst_n),
  .phy_room(phy_room), .tx_enb_n(tx_enb_n), .tx_dat(tx_dat),
  .tx_sop(tx_sop), .tx_eop(tx_eop), .tx_err(tx_err), .tx_mod(tx_mod),
  .tx_prty(tx_prty)
);

//--- ppl3_phy_model.sv
`timescale 1ns/1ps
// ***
// PHY side model
// ***
// link signals are inputs here, sampled on the link clock
module ppl3_phy_model
  import ppl3_pkg::*;
(
  input wire logic link_clk, // Link clock
  input wire logic link_rst_n, // Link reset
  input wire logic parity_odd, // Odd
  input wire logic hold, // Refuse all
  input wire logic slow, // Every other
  output logic phy_room, // Room
  input wire logic tx_enb_n, // Enable
  input wire logic [31:0] tx_dat, // Data
  input wire logic tx_sop, // Start
  input wire logic tx_eop, // End
  input wire logic tx_err, // Abort
  input wire logic [1:0] tx_mod, // Modulo
  input wire logic tx_prty // Parity
);
  ppl3_word_t got_q[$];
  int par_errs = 0;
  initial phy_room = 1'b0;
  always @(posedge link_clk) begin
    phy_room <= link_rst_n && !hold && (!slow || !phy_room);
  end
  // keep enabled words, flag parity, data untouched
  always @(posedge link_clk) begin
    if (link_rst_n && tx_enb_n === 1'b0) begin
      got_q.push_back({tx_sop, tx_eop, tx_err, tx_mod, tx_dat});
      if (tx_prty !== ((^tx_dat) ^ parity_odd)) par_errs++;
    end
  end
endmodule

//--- tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module tb_top
  import ppl3_pkg::*;
;
  typedef struct packed {
    ppl3_word_t w;
    logic [4:0] ef;
    logic keep;
  } ppl3_row_t;
  // ***
  // Offered word, flags expected at the PHY, kept
  // ***
  ppl3_row_t rows [8] = '{
    {5'h18, 32'h11223344, 5'h18, 1'h1}, {5'h13, 32'hAABBCCDD, 5'h10, 1'h1},
    {5'h04, 32'h01020304, 5'h00, 1'h1}, {5'h09, 32'h05060708, 5'h09, 1'h1},
    {5'h08, 32'hDEADBEEF, 5'h08, 1'h0}, {5'h10, 32'h0F0F0F0F, 5'h10, 1'h1},
    {5'h1E, 32'hF0F0F0F0, 5'h0E, 1'h1}, {5'h1B, 32'h80000001, 5'h1B, 1'h1}
  };
  logic clock = 1'b0, sys_rst = 1'b1, link_clk = 1'b0, link_rst_n = 1'b0;
  logic in_valid = 1'b0, in_sop = 1'b0, in_eop = 1'b0, in_err = 1'b0;
  logic [1:0] in_mod = 2'h0;
  logic [31:0] in_data = 32'h0;
  logic parity_odd = 1'b0, hold = 1'b0, slow = 1'b0;
  logic in_ready, frame_fault, phy_room, tx_enb_n, tx_sop, tx_eop, tx_err;
  logic tx_prty;
  logic [15:0] pkt_count;
  logic [31:0] tx_dat;
  logic [1:0] tx_mod;
  logic in_valid_b = 1'b0, in_ready_b, phy_room_b, txb_enb_n, txb_sop;
  logic txb_eop, txb_err, txb_prty;
  logic [31:0] txb_dat;
  logic [1:0] txb_mod;
  logic [15:0] pkt_count_b;
  int num_errors = 0, n_tests = 0, n_ff = 0;
  ppl3_word_t exp_q[$];
  always #5 clock = ~clock;
  // Odd start offset keeps the two clock domains out of phase
  initial begin
    #3.1;
    forever #6 link_clk = ~link_clk;
  end
  always @(posedge clock) if (frame_fault === 1'b1) n_ff++;
  ppl3_tx_link dut (
    .clock(clock), .sys_rst(sys_rst), .in_valid(in_valid),
    .in_ready(in_ready), .in_data(in_data), .in_sop(in_sop),
    .in_eop(in_eop), .in_err(in_err), .in_mod(in_mod),
    .parity_odd(parity_odd), .frame_fault(frame_fault),
    .pkt_count(pkt_count), .link_clk(link_clk), .link_rst_n(link_rst_n),
    .phy_room(phy_room), .tx_enb_n(tx_enb_n), .tx_dat(tx_dat),
    .tx_sop(tx_sop), .tx_eop(tx_eop), .tx_err(tx_err), .tx_mod(tx_mod),
    .tx_prty(tx_prty)
  );
  ppl3_phy_model phy (
    .link_clk(link_clk), .link_rst_n(link_rst_n), .parity_odd(parity_odd),
    .hold(hold), .slow(slow), .phy_room(phy_room), .tx_enb_n(tx_enb_n),
    .tx_dat(tx_dat), .tx_sop(tx_sop), .tx_eop(tx_eop), .tx_err(tx_err),
    .tx_mod(tx_mod), .tx_prty(tx_prty)
  );
  // Byte-wide build on the shared stimulus, fed only through in_valid_b
  ppl3_tx_link #(.BUS_BYTES(1)) dut_b (
    .clock(clock), .sys_rst(sys_rst), .in_valid(in_valid_b),
    .in_ready(in_ready_b), .in_data(in_data), .in_sop(in_sop),
    .in_eop(in_eop), .in_err(in_err), .in_mod(in_mod),
    .parity_odd(parity_odd), .frame_fault(), .pkt_count(pkt_count_b),
    .link_clk(link_clk), .link_rst_n(link_rst_n), .phy_room(phy_room_b),
    .tx_enb_n(txb_enb_n), .tx_dat(txb_dat), .tx_sop(txb_sop),
    .tx_eop(txb_eop), .tx_err(txb_err), .tx_mod(txb_mod), .tx_prty(txb_prty)
  );
  ppl3_phy_model phy_b (
    .link_clk(link_clk), .link_rst_n(link_rst_n), .parity_odd(parity_odd),
    .hold(hold), .slow(slow), .phy_room(phy_room_b), .tx_enb_n(txb_enb_n),
    .tx_dat(txb_dat), .tx_sop(txb_sop), .tx_eop(txb_eop), .tx_err(txb_err),
    .tx_mod(txb_mod), .tx_prty(txb_prty)
  );
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Called in the step of a rising edge; returns at the taking edge
  task automatic send(ppl3_word_t w, bit b = 1'b0);
    {in_sop, in_eop, in_err, in_mod, in_data} <= w;
    if (b) in_valid_b <= 1'b1;
    else in_valid <= 1'b1;
    for (int i = 0; i <= 200; i++) begin
      @(negedge clock);
      if ((b ? in_ready_b : in_ready) === 1'b1) break;
      if (i == 200) begin num_errors++; end_of_test(); end
    end
    @(posedge clock);
  endtask
  task automatic drain(string t, bit b = 1'b0);
    ppl3_word_t got[$];
    for (int i = 0; i <= 3000; i++) begin
      @(posedge link_clk);
      if (b) got = phy_b.got_q;
      else got = phy.got_q;
      if (got.size() == exp_q.size()) break;
      if (i == 3000) begin num_errors++; end_of_test(); end
    end
    foreach (exp_q[i]) `CHK("word", exp_q[i], got[i])
    `CHK("parity", 0, phy.par_errs + phy_b.par_errs)
    exp_q.delete();
    phy.got_q.delete();
    phy_b.got_q.delete();
    $display("test %s done", t);
  endtask
  initial begin
    ppl3_word_t w;
    repeat (8) @(posedge clock);
    // each reset released on its own clock
    sys_rst <= 1'b0;
    @(posedge link_clk);
    link_rst_n <= 1'b1;
    for (int s = 0; s < 2; s++) begin
      @(posedge clock);
      parity_odd <= s[0];
      slow <= s[0];
      repeat (10) @(posedge clock);
      foreach (rows[i]) begin
        send(rows[i].w);
        if (rows[i].keep) exp_q.push_back({rows[i].ef, rows[i].w.data});
      end
      in_valid <= 1'b0;
      drain("table");
    end
    `CHK("pkt_count", 16'h0008, pkt_count)
    `CHK("faults", 4, n_ff)
    // Fill while the PHY refuses, then drain against a stalling PHY
    @(posedge clock);
    hold <= 1'b1;
    for (int i = 0; i < 34; i++) begin
      if (i == 32) begin
        in_valid <= 1'b0;
        @(negedge clock);
        `CHK("in_ready", 1'b0, in_ready)
        @(posedge clock);
        hold <= 1'b0;
      end
      w = {i == 0, i == 33, 3'h0, 32'(i)};
      send(w);
      exp_q.push_back(w);
    end
    in_valid <= 1'b0;
    drain("fill");
    `CHK("pkt_count", 16'h0009, pkt_count)
    // Byte build: bytes leave high first on the low lane, markers at the ends
    @(posedge clock);
    send({5'h10, 32'h11223344}, 1'b1);
    send({5'h0E, 32'hAABBCCDD}, 1'b1);
    in_valid_b <= 1'b0;
    exp_q = '{{5'h10, 32'h11}, {5'h00, 32'h22}, {5'h00, 32'h33},
      {5'h00, 32'h44}, {5'h00, 32'hAA}, {5'h0C, 32'hBB}};
    drain("byte", 1'b1);
    `CHK("pkt_count_b", 16'h0001, pkt_count_b)
    @(posedge clock);
    send({5'h10, 32'h12345678});
    in_valid <= 1'b0;
    sys_rst <= 1'b1;
    link_rst_n <= 1'b0;
    repeat (8) @(posedge clock);
    @(negedge clock);
    `CHK("tx_enb_n", 1'b1, tx_enb_n)
    `CHK("pkt_count", 16'h0000, pkt_count)
    `CHK("in_ready", 1'b1, in_ready)
    @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge link_clk);
    link_rst_n <= 1'b1;
    phy.got_q.delete();
    @(posedge clock);
    send({5'h08, 32'h0BADF00D});
    send({5'h18, 32'hCAFEF00D});
    exp_q.push_back({5'h18, 32'hCAFEF00D});
    in_valid <= 1'b0;
    drain("reset");
    `CHK("faults", 5, n_ff)
    end_of_test();
  end
endmodule
